// ===== verilog/pcr_pkg.sv
// constants for the coding and self-test control register bank
//
// Contract
// - block-code bypass bit 12 skips 4b5b encoding
// - bit 11 free-runs receive clock
// - bit 10 enables true quiet transmit
// - bit 9 forces signal detect asserted
// - bit 8 picks detect algorithm, resets 1
// - bit 5 forces good 100 link
// - bit 2 bypasses NRZI line coding
// - bit 1 bypasses transmit scrambler
// - bit 0 bypasses receive descrambler
// - coding bits 15:13 read zero, ignore writes
// - bit 9 runs self-test, bit 10 latched pass
// - control bit 8 bypasses LED stretching
// - bit 7 reads both-sides pause capability
// - control bit 6 always reads one
// - bit 5 picks duplex indicator polarity, strapped
// - bits 4:0 port address, strapped, writable
package pcr_pkg;
    // register offsets on the management port
    localparam logic [4:0]  ADDR_CODING     = 5'h16;
    localparam logic [4:0]  ADDR_RSVD_A     = 5'h17;
    localparam logic [4:0]  ADDR_RSVD_B     = 5'h18;
    localparam logic [4:0]  ADDR_CONTROL    = 5'h19;
    localparam logic [4:0]  ADDR_IRQ_STATUS = 5'h1A;
    localparam logic [4:0]  ADDR_IRQ_MASK   = 5'h1B;

    // coding register field positions
    localparam int BIT_BLOCK_CODE_BYPASS = 12;
    localparam int BIT_RX_CLOCK_FREE     = 11;
    localparam int BIT_TRUE_QUIET        = 10;
    localparam int BIT_FORCE_SD          = 9;
    localparam int BIT_SD_ALGORITHM      = 8;
    localparam int BIT_FORCE_GOOD_LINK   = 5;
    localparam int BIT_NRZI_BYPASS       = 2;
    localparam int BIT_SCRAMBLER_SKIP    = 1;
    localparam int BIT_DESCRAMBLER_SKIP  = 0;

    // coding register writable bits and reset value
    localparam logic [15:0] CODING_WMASK = 16'h1F27;
    localparam logic [15:0] CODING_RESET = 16'h0100;

    // control register field positions
    localparam int BIT_SEQ_SELECT  = 11;
    localparam int BIT_TEST_PASS   = 10;
    localparam int BIT_TEST_RUN    = 9;
    localparam int BIT_LED_BYPASS  = 8;
    localparam int BIT_PAUSE_MATCH = 7;
    localparam int BIT_FIXED_ONE   = 6;
    localparam int BIT_DUPLEX_INDICATOR_POL    = 5;
    localparam int ADDR_FIELD_MSB  = 4;

    // control register writable bits and reset value before straps load
    localparam logic [15:0] CONTROL_WMASK = 16'h0B3F;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // interrupt event bit positions
    localparam int IRQ_TEST_FAIL   = 0;
    localparam int IRQ_PAUSE_RISE  = 1;
    localparam int IRQ_WIDTH       = 2;

    // led stretch time and its cycle count at 100 MHz
    localparam int CLOCK_MHZ       = 100;
    localparam int LED_STRETCH_MS  = 50;
    localparam int LED_STRETCH_CYC = LED_STRETCH_MS * 1000 * CLOCK_MHZ;

    // three activity indicators: receive, transmit, collision
    localparam int LED_COUNT       = 3;
endpackage

// ===== verilog/pcr_word_store.sv
// small word memory for the two reserved registers
`timescale 1ns/1ps
module pcr_word_store
    import pcr_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_rstn,
    input  wire logic                     i_clock_en,
    input  wire logic                     i_wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_wr_index,
    input  wire logic [WIDTH-1:0]         i_wr_data,
    input  wire logic                     i_rd_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_index,
    output logic      [WIDTH-1:0]         o_rd_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];   // storage words
    logic [WIDTH-1:0] rd_q;            // registered read word

    // write port, no reset value for the words themselves
    always_ff @(posedge i_clock) begin
        if (i_clock_en && i_wr_en) begin
            mem_q[i_wr_index] <= i_wr_data;
        end
    end

    // registered read port
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_q <= '0;
        end else if (i_clock_en && i_rd_en) begin
            rd_q <= mem_q[i_rd_index];
        end
    end

    assign o_rd_data = rd_q;
endmodule

// ===== verilog/pcr_regs.sv
// coding-path and self-test control register bank with interrupts
`timescale 1ns/1ps
module pcr_regs
    import pcr_pkg::*;
#(
    parameter int STRETCH_CYCLES = LED_STRETCH_CYC
) (
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic        i_clock_en,
    // management register port
    input  wire logic [4:0]  i_addr,
    input  wire logic [15:0] i_wr_data,
    input  wire logic        i_wr_strobe,
    input  wire logic        i_rd_strobe,
    output logic      [15:0] o_rd_data,
    // strap levels, held across reset
    input  wire logic [4:0]  i_strap_address,
    input  wire logic        i_strap_duplex_led_polarity,
    // status from the coding path
    input  wire logic        i_signal_detect_raw,
    input  wire logic        i_link_good_100_raw,
    input  wire logic        i_local_pause,
    input  wire logic        i_partner_pause,
    input  wire logic        i_self_test_error,
    // led activity and duplex sources
    input  wire logic        i_rx_activity,
    input  wire logic        i_tx_activity,
    input  wire logic        i_col_activity,
    input  wire logic        i_duplex_full,
    input  wire logic        i_duplex_led_invert,
    // coding path controls
    output logic             o_block_code_bypass,
    output logic             o_rx_clock_free_run,
    output logic             o_true_quiet_enable,
    output logic             o_force_signal_detect,
    output logic             o_signal_detect_algorithm_select,
    output logic             o_signal_detect,
    output logic             o_link_good_100,
    output logic             o_nrzi_bypass,
    output logic             o_scrambler_skip,
    output logic             o_descrambler_skip,
    // self-test controls
    output logic             o_self_test_run,
    output logic             o_self_test_sequence_select,
    // led, address and interrupt outputs
    output logic             o_led_rx,
    output logic             o_led_tx,
    output logic             o_led_col,
    output logic             o_duplex_indicator,
    output logic [4:0]       o_port_mgmt_address,
    output logic             o_irq
);
    // writable register bits, masked on write
    function automatic logic [15:0] masked_write(input logic [15:0] old_v,
                                                 input logic [15:0] new_v,
                                                 input logic [15:0] wmask);
        masked_write = (old_v & ~wmask) | (new_v & wmask);
    endfunction

    // strap load states
    typedef enum logic [1:0] {
        PCR_WAIT_STRAP = 2'b01,
        PCR_RUNNING    = 2'b10
    } pcr_strap_e;

    logic [15:0]          coding_q;       // coding_config_reg storage
    logic [15:0]          coding_d;
    logic [15:0]          control_q;      // writable control bits only
    logic [15:0]          control_d;
    logic                 pass_q;         // self_test_pass latch
    logic                 pass_d;
    logic                 pause_q;        // previous pause match
    logic [IRQ_WIDTH-1:0] irq_status_q;   // sticky event bits
    logic [IRQ_WIDTH-1:0] irq_status_d;
    logic [IRQ_WIDTH-1:0] irq_mask_q;     // event enables
    logic [IRQ_WIDTH-1:0] irq_events;     // this cycle's events
    logic [15:0]          rd_data_q;      // registered read word
    logic                 rd_mem_q;       // last read hit the word store
    pcr_strap_e           strap_state_q;  // strap load progress
    logic [15:0]          mem_rd_data;    // word store read data

    // address decode
    wire hit_coding  = (i_addr == ADDR_CODING);
    wire hit_rsvd    = (i_addr == ADDR_RSVD_A) || (i_addr == ADDR_RSVD_B);
    wire hit_control = (i_addr == ADDR_CONTROL);
    wire hit_status  = (i_addr == ADDR_IRQ_STATUS);
    wire hit_mask    = (i_addr == ADDR_IRQ_MASK);
    wire wr_coding   = i_wr_strobe && hit_coding;
    wire wr_control  = i_wr_strobe && hit_control;
    wire wr_status   = i_wr_strobe && hit_status;
    wire wr_mask     = i_wr_strobe && hit_mask;
    wire wr_rsvd     = i_wr_strobe && hit_rsvd;
    wire rd_rsvd     = i_rd_strobe && hit_rsvd;
    wire store_index = (i_addr == ADDR_RSVD_B);

    // pause capability on both ends
    wire pause_match = i_local_pause && i_partner_pause;

    // self-test fail only counts while the test runs
    wire test_fail   = i_self_test_error && control_q[BIT_TEST_RUN];

    // coding register next value, top bits never take writes
    assign coding_d = wr_coding ? masked_write(coding_q, i_wr_data, CODING_WMASK)
                                : coding_q;

    // control register next value
    assign control_d = wr_control ? masked_write(control_q, i_wr_data, CONTROL_WMASK)
                                  : control_q;

    // pass latch: any write to the control register clears a fail, a fail wins
    assign pass_d = test_fail  ? 1'b0 :
                    wr_control ? 1'b1 : pass_q;

    // event sources
    assign irq_events[IRQ_TEST_FAIL]  = test_fail;
    assign irq_events[IRQ_PAUSE_RISE] = pause_match && !pause_q;

    // sticky status: write one clears, a new event wins
    assign irq_status_d = (irq_status_q & ~(wr_status ? i_wr_data[IRQ_WIDTH-1:0]
                                                      : {IRQ_WIDTH{1'b0}}))
                          | irq_events;

    // assembled read values
    wire [15:0] coding_rd  = coding_q & CODING_WMASK;
    wire [15:0] control_rd = {4'h0,
                              control_q[BIT_SEQ_SELECT],
                              pass_q,
                              control_q[BIT_TEST_RUN],
                              control_q[BIT_LED_BYPASS],
                              pause_match,
                              1'b1,
                              control_q[BIT_DUPLEX_INDICATOR_POL:0]};
    wire [15:0] status_rd  = {{(16-IRQ_WIDTH){1'b0}}, irq_status_q};
    wire [15:0] mask_rd    = {{(16-IRQ_WIDTH){1'b0}}, irq_mask_q};

    // read select, unmapped addresses read zero
    wire [15:0] rd_sel = hit_coding  ? coding_rd  :
                         hit_control ? control_rd :
                         hit_status  ? status_rd  :
                         hit_mask    ? mask_rd    : 16'h0000;

    // strap capture after reset release, then normal operation
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            strap_state_q <= PCR_WAIT_STRAP;
        end else if (i_clock_en) begin
            case (strap_state_q)
                PCR_WAIT_STRAP: strap_state_q <= PCR_RUNNING;
                PCR_RUNNING:    strap_state_q <= PCR_RUNNING;
                default:        strap_state_q <= PCR_WAIT_STRAP;
            endcase
        end
    end

    // coding register
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            coding_q <= CODING_RESET;
        end else if (i_clock_en) begin
            coding_q <= coding_d;
        end
    end

    // control register, strap fields loaded in the first enabled cycle
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            control_q <= CONTROL_RESET;
        end else if (i_clock_en) begin
            if (strap_state_q == PCR_WAIT_STRAP) begin
                control_q <= {control_q[15:6], i_strap_duplex_led_polarity,
                              i_strap_address};
            end else begin
                control_q <= control_d;
            end
        end
    end

    // self-test pass latch and pause history
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            pass_q  <= 1'b0;
            pause_q <= 1'b0;
        end else if (i_clock_en) begin
            pass_q  <= pass_d;
            pause_q <= pause_match;
        end
    end

    // interrupt status and mask
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_status_q <= '0;
            irq_mask_q   <= '0;
        end else if (i_clock_en) begin
            irq_status_q <= irq_status_d;
            if (wr_mask) begin
                irq_mask_q <= i_wr_data[IRQ_WIDTH-1:0];
            end
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_data_q <= 16'h0000;
            rd_mem_q  <= 1'b0;
        end else if (i_clock_en) begin
            rd_data_q <= i_rd_strobe ? rd_sel : 16'h0000;
            rd_mem_q  <= rd_rsvd;
        end
    end

    // reserved words live in their own store
    pcr_word_store #(
        .WIDTH (16),
        .DEPTH (2)
    ) u_store (
        .i_clock    (i_clock),
        .i_rstn     (i_rstn),
        .i_clock_en (i_clock_en),
        .i_wr_en    (wr_rsvd),
        .i_wr_index (store_index),
        .i_wr_data  (i_wr_data),
        .i_rd_en    (rd_rsvd),
        .i_rd_index (store_index),
        .o_rd_data  (mem_rd_data)
    );

    assign o_rd_data = rd_mem_q ? mem_rd_data : rd_data_q;

    // led pulse stretching per activity source
    localparam int SW = $clog2(STRETCH_CYCLES + 1);
    localparam logic [SW-1:0] STRETCH_LOAD = SW'(STRETCH_CYCLES);
    logic [LED_COUNT-1:0] led_raw;        // activity inputs
    logic [LED_COUNT-1:0] led_out;        // stretched or raw
    logic [SW-1:0]        stretch_q [LED_COUNT];
    assign led_raw = {i_col_activity, i_tx_activity, i_rx_activity};

    for (genvar g = 0; g < LED_COUNT; g++) begin : g_led
        // reload on activity, count down while idle
        always_ff @(posedge i_clock or negedge i_rstn) begin
            if (!i_rstn) begin
                stretch_q[g] <= '0;
            end else if (i_clock_en) begin
                if (led_raw[g]) begin
                    stretch_q[g] <= STRETCH_LOAD;
                end else if (stretch_q[g] != '0) begin
                    stretch_q[g] <= stretch_q[g] - SW'(1);
                end
            end
        end
        // bypass drives the raw activity straight through
        assign led_out[g] = control_q[BIT_LED_BYPASS] ? led_raw[g]
                          : (led_raw[g] || stretch_q[g] != '0);
    end

    // coding path controls
    assign o_block_code_bypass   = coding_q[BIT_BLOCK_CODE_BYPASS];
    assign o_rx_clock_free_run   = coding_q[BIT_RX_CLOCK_FREE];
    assign o_true_quiet_enable   = coding_q[BIT_TRUE_QUIET];
    assign o_force_signal_detect = coding_q[BIT_FORCE_SD];
    assign o_signal_detect_algorithm_select = coding_q[BIT_SD_ALGORITHM];
    assign o_signal_detect  = i_signal_detect_raw || coding_q[BIT_FORCE_SD];
    assign o_link_good_100  = i_link_good_100_raw
                              || coding_q[BIT_FORCE_GOOD_LINK];
    assign o_nrzi_bypass      = coding_q[BIT_NRZI_BYPASS];
    assign o_scrambler_skip   = coding_q[BIT_SCRAMBLER_SKIP];
    assign o_descrambler_skip = coding_q[BIT_DESCRAMBLER_SKIP];

    // self-test controls
    assign o_self_test_run             = control_q[BIT_TEST_RUN];
    assign o_self_test_sequence_select = control_q[BIT_SEQ_SELECT];

    // led and address outputs
    assign o_led_rx  = led_out[0];
    assign o_led_tx  = led_out[1];
    assign o_led_col = led_out[2];
    assign o_duplex_indicator = control_q[BIT_DUPLEX_INDICATOR_POL]
                                ? (i_duplex_full ^ i_duplex_led_invert)
                                : i_duplex_full;
    assign o_port_mgmt_address = control_q[ADDR_FIELD_MSB:0];

    // level interrupt from unmasked sticky bits
    assign o_irq = |(irq_status_q & irq_mask_q);
endmodule

// ===== dv/pcr_regs_monitor.sv
// checker of the coding and self-test register bank port behaviour
`timescale 1ns/1ps
module pcr_regs_monitor
    import pcr_pkg::*;
#(
    parameter int STRETCH_CYCLES = 8
) (
    input wire logic        i_clock,
    input wire logic        i_rstn,
    input wire logic        i_clock_en,
    input wire logic [4:0]  i_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic        i_wr_strobe,
    input wire logic        i_rd_strobe,
    input wire logic [15:0] o_rd_data,
    input wire logic [4:0]  i_strap_address,
    input wire logic        i_signal_detect_raw,
    input wire logic        i_local_pause,
    input wire logic        i_partner_pause,
    input wire logic        i_self_test_error,
    input wire logic        o_block_code_bypass,
    input wire logic        o_force_signal_detect,
    input wire logic        o_signal_detect_algorithm_select,
    input wire logic        o_signal_detect,
    input wire logic        o_self_test_run,
    input wire logic        o_self_test_sequence_select,
    input wire logic [4:0]  o_port_mgmt_address,
    input wire logic        o_irq
);
    // requests taken at this edge, by register
    wire wr_cod = i_clock_en & i_wr_strobe & (i_addr == ADDR_CODING);
    wire rd_cod = i_clock_en & i_rd_strobe & (i_addr == ADDR_CODING);
    wire wr_ctl = i_clock_en & i_wr_strobe & (i_addr == ADDR_CONTROL);
    wire rd_ctl = i_clock_en & i_rd_strobe & (i_addr == ADDR_CONTROL);
    wire pause2 = i_local_pause & i_partner_pause;  // both sides pause capable

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    property p_coding_write;
        wr_cod |=> o_block_code_bypass == $past(i_wr_data[12])
            && o_signal_detect_algorithm_select == $past(i_wr_data[8]);
    endproperty
    a_coding_write: assert property (p_coding_write)
        else $error("coding write not applied");
    property p_force_detect;
        o_signal_detect == (i_signal_detect_raw | o_force_signal_detect);
    endproperty
    a_force_detect: assert property (p_force_detect)
        else $error("signal detect not forced");
    property p_coding_read;
        rd_cod |=> o_rd_data[15:13] == 3'h0 && o_rd_data[12] == o_block_code_bypass
            && o_rd_data[8] == o_signal_detect_algorithm_select;
    endproperty
    a_coding_read: assert property (p_coding_read)
        else $error("coding readback wrong");
    property p_control_read;
        rd_ctl |=> o_rd_data[6] == 1'b1 && o_rd_data[15:12] == 4'h0
            && o_rd_data[4:0] == o_port_mgmt_address
            && o_rd_data[11] == o_self_test_sequence_select;
    endproperty
    a_control_read: assert property (p_control_read)
        else $error("control readback wrong");
    property p_control_write;
        wr_ctl |=> o_self_test_run == $past(i_wr_data[9])
            && o_self_test_sequence_select == $past(i_wr_data[11])
            && o_port_mgmt_address == $past(i_wr_data[4:0]);
    endproperty
    a_control_write: assert property (p_control_write)
        else $error("control write not applied");
    property p_pause_read;
        rd_ctl && pause2 == $past(pause2) |=> o_rd_data[7] == $past(pause2);
    endproperty
    a_pause_read: assert property (p_pause_read)
        else $error("pause match bit wrong");
    property p_strap_load;
        $rose(i_rstn) && i_clock_en |=> o_port_mgmt_address == $past(i_strap_address);
    endproperty
    a_strap_load: assert property (p_strap_load)
        else $error("strapped address not loaded");
    property p_pass_latch;
        wr_ctl && !i_self_test_error ##1 !i_self_test_error ##1 rd_ctl |=> o_rd_data[10];
    endproperty
    a_pass_latch: assert property (p_pass_latch)
        else $error("pass not set by control write");

    // main scenarios reached
    c_irq_rise: cover property ($rose(o_irq));
    c_fail_read: cover property (rd_ctl ##1 o_rd_data[10] == 1'b0);
    c_strap: cover property ($rose(i_rstn));
endmodule

bind pcr_regs pcr_regs_monitor #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_monitor (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_clock_en(i_clock_en), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe),
    .o_rd_data(o_rd_data), .i_strap_address(i_strap_address),
    .i_signal_detect_raw(i_signal_detect_raw), .i_local_pause(i_local_pause),
    .i_partner_pause(i_partner_pause), .i_self_test_error(i_self_test_error),
    .o_block_code_bypass(o_block_code_bypass), .o_force_signal_detect(o_force_signal_detect),
    .o_signal_detect_algorithm_select(o_signal_detect_algorithm_select),
    .o_signal_detect(o_signal_detect), .o_self_test_run(o_self_test_run),
    .o_self_test_sequence_select(o_self_test_sequence_select),
    .o_port_mgmt_address(o_port_mgmt_address), .o_irq(o_irq));

// ===== dv/pcr_mgmt_master.sv
// management master model driving the register port of the bank
`timescale 1ns/1ps
module pcr_mgmt_master
    import pcr_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic [15:0] i_rd_data,
    output logic      [4:0]  o_addr,
    output logic      [15:0] o_wr_data,
    output logic             o_wr_strobe,
    output logic             o_rd_strobe
);
    // idle bus at time zero
    initial begin
        {o_addr, o_wr_data, o_wr_strobe, o_rd_strobe} = '0;
    end

    // one-cycle write, none for the reserved addresses; stale address and data inverted once released
    task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
        if (a == ADDR_RSVD_A || a == ADDR_RSVD_B) begin
            return;
        end
        @(posedge i_clock);
        o_addr      <= a;
        o_wr_data   <= d;
        o_wr_strobe <= 1'b1;
        @(posedge i_clock);
        o_wr_strobe <= 1'b0;
        o_wr_data   <= ~d;
        o_addr      <= ~a;
        #1;
    endtask

    // one-cycle read; data taken in the cycle after the strobe
    task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
        @(posedge i_clock);
        o_addr      <= a;
        o_rd_strobe <= 1'b1;
        @(posedge i_clock);
        o_rd_strobe <= 1'b0;
        o_addr      <= ~a;
        #1;
        d = i_rd_data;
    endtask
endmodule

// ===== dv/pcs_and_phy_control_regs_tb.sv
// self-checking bench for the coding and self-test register bank
`timescale 1ns/1ps
module pcs_and_phy_control_regs_tb
    import pcr_pkg::*;
;
    localparam int STRETCH = 8;             // short led stretch for simulation
    logic        clk = 1'b0, rstn, cen;     // clock, reset, clock enable
    logic [4:0]  strap_a;                   // strapped port address
    logic        strap_p, sd_raw, lk_raw;   // strap polarity, raw detect and link
    logic        lp, pp, err, rx, tx, col;  // pause, test error, activity
    logic        dfull, dinv;               // duplex sources
    wire  [4:0]  addr, paddr;
    wire  [15:0] wdata, rdata;
    wire  [15:0] cv;                        // coding outputs at their bit positions
    assign {cv[15:13], cv[7:6], cv[4:3]} = 7'h00;  // positions with no output
    wire         wr, rd, sdet, run, seq, lrx, ltx, lcol, dind, irq;
    logic [15:0] r, w;                      // read word, written word
    int          mismatches, checks_done;
    int          cbits[9] = '{12, 11, 10, 9, 8, 5, 2, 1, 0};

    always #5 clk = ~clk;

    pcr_mgmt_master mgmt (.i_clock(clk), .i_rd_data(rdata), .o_addr(addr),
        .o_wr_data(wdata), .o_wr_strobe(wr), .o_rd_strobe(rd));

    pcr_regs #(.STRETCH_CYCLES(STRETCH)) dut (
        .i_clock(clk), .i_rstn(rstn), .i_clock_en(cen), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_strobe(wr), .i_rd_strobe(rd), .o_rd_data(rdata), .i_strap_address(strap_a),
        .i_strap_duplex_led_polarity(strap_p), .i_signal_detect_raw(sd_raw),
        .i_link_good_100_raw(lk_raw), .i_local_pause(lp), .i_partner_pause(pp),
        .i_self_test_error(err), .i_rx_activity(rx), .i_tx_activity(tx), .i_col_activity(col),
        .i_duplex_full(dfull), .i_duplex_led_invert(dinv), .o_block_code_bypass(cv[12]),
        .o_rx_clock_free_run(cv[11]), .o_true_quiet_enable(cv[10]),
        .o_force_signal_detect(cv[9]), .o_signal_detect_algorithm_select(cv[8]),
        .o_signal_detect(sdet), .o_link_good_100(cv[5]), .o_nrzi_bypass(cv[2]),
        .o_scrambler_skip(cv[1]), .o_descrambler_skip(cv[0]), .o_self_test_run(run),
        .o_self_test_sequence_select(seq), .o_led_rx(lrx), .o_led_tx(ltx), .o_led_col(lcol),
        .o_duplex_indicator(dind), .o_port_mgmt_address(paddr), .o_irq(irq));

    // compare one result word
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // counts, verdict, end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // wait one edge and let its updates land
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // hang guard, far beyond the fewer than one hundred cycles the tests take
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    // test sequence
    initial begin
        {rstn, sd_raw, lk_raw, lp, pp, err, rx, tx, col, dfull, dinv} = '0;
        cen = 1'b1;
        strap_a = 5'h13;
        strap_p = 1'b1;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1 chk(cv & CODING_WMASK, CODING_RESET);
        repeat (2) tick();
        chk({11'h0, paddr}, {11'h0, strap_a});
        mgmt.read_reg(ADDR_CODING, r);
        chk(r, CODING_RESET);
        mgmt.read_reg(ADDR_CONTROL, r);
        chk(r, 16'h0073);
        $display("test reset done");
        // each coding bit alone, then all ones and all zeros
        foreach (cbits[i]) begin
            w = 16'h0001 << cbits[i];
            mgmt.write_reg(ADDR_CODING, w);
            chk(cv & CODING_WMASK, w);
            chk({15'h0, sdet}, {15'h0, w[9]});
        end
        mgmt.write_reg(ADDR_CODING, 16'hFFFF);
        mgmt.read_reg(ADDR_CODING, r);
        chk(r, CODING_WMASK);
        mgmt.write_reg(ADDR_CODING, 16'h0000);
        chk(cv & CODING_WMASK, 16'h0000);
        $display("test coding done");
        // control bits, pause match, masked then unmasked interrupt
        mgmt.write_reg(ADDR_CONTROL, 16'hFFFF);
        chk({9'h0, run, seq, paddr}, {9'h0, 2'h3, 5'h1F});
        mgmt.read_reg(ADDR_CONTROL, r);
        chk(r, 16'h0F7F);
        @(posedge clk) {lp, pp} <= 2'h3;
        mgmt.read_reg(ADDR_CONTROL, r);
        chk(r, 16'h0FFF);
        chk({15'h0, irq}, 16'h0000);
        mgmt.read_reg(ADDR_IRQ_STATUS, r);
        chk(r, 16'h0002);
        mgmt.write_reg(ADDR_IRQ_MASK, 16'h0003);
        tick();
        chk({15'h0, irq}, 16'h0001);
        mgmt.write_reg(ADDR_IRQ_STATUS, 16'h0002);
        tick();
        chk({15'h0, irq}, 16'h0000);
        $display("test control done");
        // self-test fail latches until the control register is written
        @(posedge clk) err <= 1'b1;
        @(posedge clk) err <= 1'b0;
        #1 chk({15'h0, irq}, 16'h0001);
        mgmt.read_reg(ADDR_CONTROL, r);
        chk(r, 16'h0BFF);
        mgmt.write_reg(ADDR_IRQ_STATUS, 16'h0001);
        tick();
        chk({15'h0, irq}, 16'h0000);
        @(posedge clk) {dfull, dinv} <= 2'h3;
        mgmt.write_reg(ADDR_CONTROL, 16'h0B3F);
        chk({15'h0, dind}, 16'h0000);
        mgmt.read_reg(ADDR_CONTROL, r);
        chk(r, 16'h0FFF);
        mgmt.write_reg(ADDR_CONTROL, 16'h0000);
        chk({13'h0, run, seq, dind}, 16'h0001);
        $display("test self-test done");
        // led stretching bypassed, then applied
        mgmt.write_reg(ADDR_CONTROL, 16'h0100);
        @(posedge clk) {rx, tx, col} <= 3'h7;
        #1 chk({13'h0, lrx, ltx, lcol}, 16'h0007);
        @(posedge clk) {rx, tx, col} <= 3'h0;
        #1 chk({13'h0, lrx, ltx, lcol}, 16'h0000);
        mgmt.write_reg(ADDR_CONTROL, 16'h0000);
        @(posedge clk) {rx, tx, col} <= 3'h7;
        @(posedge clk) {rx, tx, col} <= 3'h0;
        tick();
        chk({13'h0, lrx, ltx, lcol}, 16'h0007);
        repeat (STRETCH + 4) tick();
        chk({13'h0, lrx, ltx, lcol}, 16'h0000);
        $display("test led done");
        // unmapped address ignores writes and reads zero
        mgmt.write_reg(5'h05, 16'hFFFF);
        mgmt.read_reg(5'h05, r);
        chk(r, 16'h0000);
        mgmt.read_reg(5'h1C, r);
        chk(r, 16'h0000);
        $display("test unmapped done");
        complete_run();
    end
endmodule
